//--- hw/rx_timer_pkg.sv
// Shared constants, register map and state encoding for the receive response timers
package rx_timer_pkg;
   // Core clock rate and the reader reference oscillator that defines the timer steps
   localparam int CLOCK_MHZ = 100;
   localparam int REF_KHZ_X10 = 135600;
   localparam int REF_CYCLES_BLANK_STEP = 128;
   localparam int REF_CYCLES_SILENCE_STEP = 512;
   // Step lengths in ns, rounded up from whole reference cycles; the common factor keeps products within 32 bits
   localparam int NS_SCALE = 40;
   localparam int REF_DIV = REF_KHZ_X10 / NS_SCALE;
   localparam int BLANK_STEP_NS = (REF_CYCLES_BLANK_STEP * (10000000 / NS_SCALE) + REF_DIV - 1) / REF_DIV;
   localparam int SILENCE_STEP_NS = (REF_CYCLES_SILENCE_STEP * (10000000 / NS_SCALE) + REF_DIV - 1) / REF_DIV;
   // Least times: round up to whole core cycles
   localparam int BLANK_STEP_CYCLES = (BLANK_STEP_NS * CLOCK_MHZ + 999) / 1000;
   localparam int SILENCE_STEP_CYCLES = (SILENCE_STEP_NS * CLOCK_MHZ + 999) / 1000;
   // Protocol presets in us, turned into the nearest step count
   localparam int SILENCE_HIGH_RATE_US = 755;
   localparam int SILENCE_LOW_RATE_US = 1812;
   localparam int BLANK_MIN_RESPONSE_US = 293;
   localparam logic [7:0] SILENCE_PRESET_HIGH =
      8'((SILENCE_HIGH_RATE_US * 1000 + SILENCE_STEP_NS / 2) / SILENCE_STEP_NS);
   localparam logic [7:0] SILENCE_PRESET_LOW =
      8'((SILENCE_LOW_RATE_US * 1000 + SILENCE_STEP_NS / 2) / SILENCE_STEP_NS);
   localparam logic [7:0] BLANK_PRESET =
      8'((BLANK_MIN_RESPONSE_US * 1000 + BLANK_STEP_NS / 2) / BLANK_STEP_NS);
   localparam logic [7:0] SILENCE_DEFAULT = 8'h0e;
   // Register map
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] PROTOCOL_CONTROL_ADDR = 8'h01;
   localparam logic [7:0] NO_RESPONSE_WAIT_TIME_ADDR = 8'h07;
   localparam logic [7:0] RECEIVE_BLANKING_TIME_ADDR = 8'h08;
   localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0c;
   // Field layout
   localparam int PROTOCOL_FIELD_W = 5;
   localparam int HIGH_RATE_BIT = 1;
   localparam int SILENCE_FLAG_BIT = 0;
   localparam logic [4:0] PROTOCOL_DEFAULT = 5'h02;
   localparam logic [7:0] READ_ZERO = 8'h00;
   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_BLANKING = 2'b01,
      LINK_WAITING = 2'b10
   } link_state_t;
endpackage

//--- hw/timer_if.sv
// Control and status signals between the timer owner and one step timer
`timescale 1ns/1ns
interface timer_if;
   logic start;
   logic stop;
   logic [7:0] value;
   logic running;
   logic done;
   modport ctl(output start, output stop, output value, input running, input done);
   modport tmr(input start, input stop, input value, output running, output done);
endinterface

//--- hw/step_timer.sv
// Down-counting timer of programmable whole steps with a prescaler
`timescale 1ns/1ns
module step_timer #(
   parameter int STEP_CYCLES = 944
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ce,
   timer_if.tmr tif
);
   localparam int PRE_W = $clog2(STEP_CYCLES) + 1;
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

   if (STEP_CYCLES < 2 || STEP_CYCLES * 255 >= (1 << 24)) begin : g_check
      $error("step_timer: STEP_CYCLES out of range");
   end

   logic [PRE_W-1:0] pre, next_pre;
   logic [7:0] units, next_units;
   logic running, next_running;
   logic done, next_done;

   // A value of zero leaves the timer idle: no wait, no expiry
   always_comb begin
      next_pre = pre;
      next_units = units;
      next_running = running;
      next_done = 1'b0;
      if (tif.stop) begin
         next_running = 1'b0;
      end else if (tif.start) begin
         next_running = (tif.value != 8'h00);
         next_pre = PRE_LAST;
         next_units = tif.value;
      end else if (running) begin
         if (pre == '0) begin
            next_pre = PRE_LAST;
            if (units == 8'h01) begin
               next_running = 1'b0;
               next_done = 1'b1;
            end else begin
               next_units = units - 8'h01;
            end
         end else begin
            next_pre = pre - PRE_W'(1);
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pre <= '0;
         units <= 8'h00;
         running <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         pre <= next_pre;
         units <= next_units;
         running <= next_running;
         done <= next_done;
      end
   end

   assign tif.running = running;
   assign tif.done = done;

   // Helper: clock-enabled cycles since the last start, and the value it took
   logic [23:0] elapsed;
   logic [7:0] started_value;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         elapsed <= 24'h000000;
         started_value <= 8'h00;
      end else if (ce) begin
         if (tif.start && !tif.stop) begin
            elapsed <= 24'h000000;
            started_value <= tif.value;
         end else if (running) begin
            elapsed <= elapsed + 24'h000001;
         end
      end
   end

   AST_STEP_LENGTH: assert property (@(posedge clock) disable iff (!arst_n) // [RQ3] [RQ4] [RQ9] [RQ13]
      $rose(done) |-> elapsed == 24'(started_value * STEP_CYCLES))
      else $error("Timer expired after the wrong number of cycles");
endmodule

//--- hw/rx_response_timers.sv
// Receive blanking and no-response timers with their register port
//
// How it works
// RQ1: A silence timer runs from each slot start until a tag answer begins.
// RQ2: Silence timeout without answer sets the status flag and raises the interrupt.
// RQ3: One silence step equals 37.76 us.
// RQ4: Silence register is eight bits; 1 to 255 steps reach 9628 us.
// RQ5: Silence counting starts when the transmitted end of frame finishes.
// RQ6: Silence register returns to 0x0e on reset and while enable is low.
// RQ7: Protocol writes preset silence to 755 us high rate, 1812 us low rate.
// RQ8: After transmit, decoders stay in reset for the programmed blanking time.
// RQ9: Blanking register is eight bits, 9.44 us steps, up to 2407 us.
// RQ10: Blanking starts at end of frame; the receive input is ignored meanwhile.
// RQ11: Protocol writes preset blanking to the 293 us minimum response time.
// RQ12: The protocol field's rate bit selects high or low rate presets.
// RQ13: Steps come from 128 and 512 reference cycles of 13.56 MHz.
// RQ14: Both timer registers read back and may be overwritten after presets.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
module rx_response_timers (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic enable_pin,
   input wire logic rx_pin,
   input wire logic tx_eof_done,
   input wire logic rx_response_start,
   input wire logic [rx_timer_pkg::ADDR_W-1:0] addr,
   input wire logic [rx_timer_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [rx_timer_pkg::DATA_W-1:0] rdata,
   output logic irq,
   output logic decoder_hold,
   output logic rx_gated
);
   timer_if silence_if();
   timer_if blank_if();

   step_timer #(
      .STEP_CYCLES(rx_timer_pkg::SILENCE_STEP_CYCLES) // [RQ3] [RQ4] [RQ13]
   ) u_silence (
      .clock(clock),
      .arst_n(arst_n),
      .ce(ce),
      .tif(silence_if.tmr)
   );

   step_timer #(
      .STEP_CYCLES(rx_timer_pkg::BLANK_STEP_CYCLES) // [RQ9] [RQ13]
   ) u_blank (
      .clock(clock),
      .arst_n(arst_n),
      .ce(ce),
      .tif(blank_if.tmr)
   );

   // Pin synchronisers: the first stage feeds only the second
   logic [2:0] enable_sync, next_enable_sync;
   logic [2:0] rx_sync, next_rx_sync;
   logic enable_level, next_enable_level;
   logic rx_level, next_rx_level;

   always_comb begin
      next_enable_sync = {enable_sync[1:0], enable_pin};
      next_rx_sync = {rx_sync[1:0], rx_pin};
      next_enable_level = enable_level;
      next_rx_level = rx_level;
      if (enable_sync[1] == enable_sync[2]) begin
         next_enable_level = enable_sync[2];
      end
      if (rx_sync[1] == rx_sync[2]) begin
         next_rx_level = rx_sync[2];
      end
   end

   // Enable starts low so the registers hold their defaults until the pin is seen high
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         enable_sync <= 3'h0;
         rx_sync <= 3'h0;
         enable_level <= 1'b0;
         rx_level <= 1'b0;
      end else if (ce) begin
         enable_sync <= next_enable_sync;
         rx_sync <= next_rx_sync;
         enable_level <= next_enable_level;
         rx_level <= next_rx_level;
      end
   end

   // Register file
   logic [rx_timer_pkg::PROTOCOL_FIELD_W-1:0] protocol, next_protocol;
   logic [7:0] no_response_wait_time, next_no_response_wait_time;
   logic [7:0] receive_blanking_time, next_receive_blanking_time;
   logic silence_flag, next_silence_flag;
   logic [7:0] next_rdata;
   logic proto_write, status_read;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
      return a == reg_addr;
   endfunction

   assign proto_write = wr && hit(addr, rx_timer_pkg::PROTOCOL_CONTROL_ADDR);
   assign status_read = rd && hit(addr, rx_timer_pkg::IRQ_STATUS_ADDR);

   always_comb begin
      next_protocol = protocol;
      next_no_response_wait_time = no_response_wait_time;
      next_receive_blanking_time = receive_blanking_time;
      next_silence_flag = silence_flag;
      next_rdata = rx_timer_pkg::READ_ZERO;
      if (!enable_level) begin
         next_protocol = rx_timer_pkg::PROTOCOL_DEFAULT;
         next_no_response_wait_time = rx_timer_pkg::SILENCE_DEFAULT; // [RQ6]
         next_receive_blanking_time = rx_timer_pkg::BLANK_PRESET;
         next_silence_flag = 1'b0;
      end else begin
         if (proto_write) begin
            next_protocol = wdata[rx_timer_pkg::PROTOCOL_FIELD_W-1:0];
            // The rate bit picks the preset; every protocol write overrides earlier tuning
            if (wdata[rx_timer_pkg::HIGH_RATE_BIT]) begin // [RQ12]
               next_no_response_wait_time = rx_timer_pkg::SILENCE_PRESET_HIGH; // [RQ7]
            end else begin
               next_no_response_wait_time = rx_timer_pkg::SILENCE_PRESET_LOW; // [RQ7]
            end
            next_receive_blanking_time = rx_timer_pkg::BLANK_PRESET; // [RQ11]
         end
         if (wr && hit(addr, rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR)) begin
            next_no_response_wait_time = wdata; // [RQ14]
         end
         if (wr && hit(addr, rx_timer_pkg::RECEIVE_BLANKING_TIME_ADDR)) begin
            next_receive_blanking_time = wdata; // [RQ14]
         end
         // Reading status clears it, but a timeout in the same cycle survives
         if (status_read) begin
            next_silence_flag = 1'b0;
         end
         if (silence_if.done) begin
            next_silence_flag = 1'b1; // [RQ2]
         end
      end
      if (rd) begin
         case (addr)
            rx_timer_pkg::PROTOCOL_CONTROL_ADDR: begin
               next_rdata = 8'(protocol);
            end
            rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR: begin
               next_rdata = no_response_wait_time; // [RQ14]
            end
            rx_timer_pkg::RECEIVE_BLANKING_TIME_ADDR: begin
               next_rdata = receive_blanking_time; // [RQ14]
            end
            rx_timer_pkg::IRQ_STATUS_ADDR: begin
               next_rdata = 8'(silence_flag) << rx_timer_pkg::SILENCE_FLAG_BIT;
            end
            default: begin
               next_rdata = rx_timer_pkg::READ_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         protocol <= rx_timer_pkg::PROTOCOL_DEFAULT;
         no_response_wait_time <= rx_timer_pkg::SILENCE_DEFAULT; // [RQ6]
         receive_blanking_time <= rx_timer_pkg::BLANK_PRESET;
         silence_flag <= 1'b0;
         rdata <= rx_timer_pkg::READ_ZERO;
      end else if (ce) begin
         protocol <= next_protocol;
         no_response_wait_time <= next_no_response_wait_time;
         receive_blanking_time <= next_receive_blanking_time;
         silence_flag <= next_silence_flag;
         rdata <= next_rdata;
      end
   end

   // Exchange sequencing
   rx_timer_pkg::link_state_t state, next_state;
   logic next_decoder_hold, next_rx_gated, next_irq;
   logic answer_seen;

   // Answers are only believed once the decoders are out of reset
   assign answer_seen = rx_response_start && (state == rx_timer_pkg::LINK_WAITING);

   always_comb begin
      next_state = state;
      silence_if.start = 1'b0;
      silence_if.stop = 1'b0;
      silence_if.value = no_response_wait_time;
      blank_if.start = 1'b0;
      blank_if.stop = 1'b0;
      blank_if.value = receive_blanking_time;
      if (!enable_level) begin
         silence_if.stop = 1'b1;
         blank_if.stop = 1'b1;
         next_state = rx_timer_pkg::LINK_IDLE;
      end else if (tx_eof_done) begin
         // Both intervals are measured from the end of the transmitted frame
         silence_if.start = 1'b1; // [RQ5] [RQ1]
         blank_if.start = 1'b1; // [RQ10]
         if (receive_blanking_time != 8'h00) begin
            next_state = rx_timer_pkg::LINK_BLANKING;
         end else begin
            next_state = rx_timer_pkg::LINK_WAITING;
         end
      end else begin
         case (state)
            rx_timer_pkg::LINK_IDLE: begin
               next_state = rx_timer_pkg::LINK_IDLE;
            end
            rx_timer_pkg::LINK_BLANKING: begin
               if (blank_if.done) begin
                  next_state = rx_timer_pkg::LINK_WAITING; // [RQ8]
               end
            end
            rx_timer_pkg::LINK_WAITING: begin
               if (answer_seen) begin
                  silence_if.stop = 1'b1; // [RQ1]
                  next_state = rx_timer_pkg::LINK_IDLE;
               end
            end
            default: begin
               next_state = rx_timer_pkg::LINK_IDLE;
            end
         endcase
      end
      next_decoder_hold = (next_state == rx_timer_pkg::LINK_BLANKING); // [RQ8]
      next_rx_gated = rx_level && (next_state != rx_timer_pkg::LINK_BLANKING); // [RQ10]
      next_irq = next_silence_flag; // [RQ2]
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= rx_timer_pkg::LINK_IDLE;
         decoder_hold <= 1'b0;
         rx_gated <= 1'b0;
         irq <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         decoder_hold <= next_decoder_hold;
         rx_gated <= next_rx_gated;
         irq <= next_irq;
      end
   end

   // Checks
   sequence eof_accepted;
      ce && enable_level && tx_eof_done;
   endsequence

   sequence silence_timeout;
      ce && enable_level && silence_if.done;
   endsequence

   sequence blanking_live;
      ce && enable_level && !tx_eof_done && state == rx_timer_pkg::LINK_BLANKING;
   endsequence

   AST_TIMEOUT_FLAGS: assert property (@(posedge clock) disable iff (!arst_n) // [RQ2]
      silence_timeout |=> silence_flag && irq)
      else $error("Silence timeout did not raise flag and interrupt");

   AST_IRQ_CAUSE: assert property (@(posedge clock) disable iff (!arst_n) // [RQ2]
      $rose(irq) |-> $past(silence_if.done))
      else $error("Interrupt rose without a silence timeout");

   AST_DISABLE_DEFAULT: assert property (@(posedge clock) disable iff (!arst_n) // [RQ6]
      ce && !enable_level
      |=> no_response_wait_time == rx_timer_pkg::SILENCE_DEFAULT && state == rx_timer_pkg::LINK_IDLE)
      else $error("Silence register not at default while disabled");

   AST_RATE_PRESET: assert property (@(posedge clock) disable iff (!arst_n) // [RQ7] [RQ12]
      ce && enable_level && proto_write
      |=> no_response_wait_time == ($past(wdata[rx_timer_pkg::HIGH_RATE_BIT]) ?
          rx_timer_pkg::SILENCE_PRESET_HIGH : rx_timer_pkg::SILENCE_PRESET_LOW))
      else $error("Silence preset does not match the selected rate");

   AST_BLANK_PRESET: assert property (@(posedge clock) disable iff (!arst_n) // [RQ11]
      ce && enable_level && proto_write |=> receive_blanking_time == rx_timer_pkg::BLANK_PRESET)
      else $error("Blanking not preset on protocol write");

   AST_EOF_BLANKS: assert property (@(posedge clock) disable iff (!arst_n) // [RQ8] [RQ10]
      eof_accepted ##0 (receive_blanking_time != 8'h00) |=> decoder_hold && !rx_gated)
      else $error("Decoders not held after end of frame");

   AST_EOF_STARTS_SILENCE: assert property (@(posedge clock) disable iff (!arst_n) // [RQ5]
      eof_accepted ##0 (no_response_wait_time != 8'h00) |=> silence_if.running)
      else $error("Silence timer did not start at end of frame");

   AST_RX_MASKED: assert property (@(posedge clock) disable iff (!arst_n) // [RQ10]
      decoder_hold |-> !rx_gated)
      else $error("Receive input passed while decoders are held");

   AST_ANSWER_STOPS: assert property (@(posedge clock) disable iff (!arst_n) // [RQ1]
      ce && enable_level && answer_seen && !tx_eof_done |=> !silence_if.running ##1 !silence_if.done)
      else $error("Tag answer did not stop the silence timer");

   AST_READBACK: assert property (@(posedge clock) disable iff (!arst_n) // [RQ14]
      ce && rd && hit(addr, rx_timer_pkg::RECEIVE_BLANKING_TIME_ADDR)
      |=> rdata == $past(receive_blanking_time))
      else $error("Blanking register read back wrong");

   AST_STATUS_CLEAR: assert property (@(posedge clock) disable iff (!arst_n) // [RQ2]
      ce && enable_level && status_read && !silence_if.done |=> !silence_flag && !irq)
      else $error("Status read did not clear the silence flag");

   AST_SET_WINS: assert property (@(posedge clock) disable iff (!arst_n) // [RQ2]
      silence_timeout ##0 status_read |=> silence_flag && irq)
      else $error("Timeout lost against a status read in the same cycle");

   AST_WRITE_SILENCE: assert property (@(posedge clock) disable iff (!arst_n) // [RQ14]
      ce && enable_level && wr && hit(addr, rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR)
      |=> no_response_wait_time == $past(wdata))
      else $error("Silence register write did not land");

   AST_WRITE_BLANK: assert property (@(posedge clock) disable iff (!arst_n) // [RQ14]
      ce && enable_level && wr && hit(addr, rx_timer_pkg::RECEIVE_BLANKING_TIME_ADDR)
      |=> receive_blanking_time == $past(wdata))
      else $error("Blanking register write did not land");

   AST_BLANK_ENDS: assert property (@(posedge clock) disable iff (!arst_n) // [RQ8]
      blanking_live ##0 blank_if.done |=> !decoder_hold && state == rx_timer_pkg::LINK_WAITING)
      else $error("Decoders still held after the blanking time");

   AST_BLANK_IGNORES_ANSWER: assert property (@(posedge clock) disable iff (!arst_n) // [RQ10]
      blanking_live ##0 (rx_response_start && silence_if.running) |=> silence_if.running || silence_if.done)
      else $error("Answer during blanking stopped the silence timer");

   AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!arst_n) // [RQ14]
      ce && !rd |=> rdata == rx_timer_pkg::READ_ZERO)
      else $error("Read data not zero outside the read cycle");

   AST_PROTOCOL_STORE: assert property (@(posedge clock) disable iff (!arst_n) // [RQ12]
      ce && enable_level && proto_write |=> protocol == $past(wdata[rx_timer_pkg::PROTOCOL_FIELD_W-1:0]))
      else $error("Protocol field not stored on write");

   AST_DISABLED_QUIET: assert property (@(posedge clock) disable iff (!arst_n) // [RQ6]
      ce && !enable_level |=> !decoder_hold && !silence_if.running && !irq)
      else $error("Timers or interrupt active while disabled");
endmodule

//--- testbench/rfid_tag_model.sv
// Behavioural transponder that answers a reader frame after a chosen delay
`timescale 1ns/1ns
module rfid_tag_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic tx_eof_done,
   input wire logic answer_en,
   input wire logic [15:0] answer_delay,
   output logic rx_pin,
   output logic rx_response_start
);
   logic [15:0] count;

   // Field disturbance keeps the receive line busy, so only the blanking gate can quiet it
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count <= 16'h0000;
         rx_pin <= 1'b0;
         rx_response_start <= 1'b0;
      end else begin
         rx_pin <= 1'b1;
         rx_response_start <= 1'b0;
         if (tx_eof_done && answer_en) begin
            count <= answer_delay;
         end else if (count > 16'h0001) begin
            count <= count - 16'h0001;
         end else if (count == 16'h0001) begin
            count <= 16'h0000;
            rx_response_start <= 1'b1;
         end
      end
   end
endmodule

//--- testbench/test_rx_response_timers.sv
// Self-checking bench for the receive response timers
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("[FAIL] %0t value %h expected %h", $time, got, exp); end end
module test_rx_response_timers;
   localparam int BS = rx_timer_pkg::BLANK_STEP_CYCLES;
   localparam int SS = rx_timer_pkg::SILENCE_STEP_CYCLES;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic enable_pin = 1'b1;
   logic rx_pin;
   logic tx_eof_done = 1'b0;
   logic rx_response_start;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic irq;
   logic decoder_hold;
   logic rx_gated;
   logic answer_en = 1'b0;
   logic [15:0] answer_delay = 16'h0000;
   logic rd_seen = 1'b0;
   logic [7:0] expect_q[$];
   int mismatches = 0;
   int n_checks = 0;

   always #5 clock = ~clock;

   rx_response_timers i_dut (
      .clock(clock), .arst_n(arst_n), .ce(ce), .enable_pin(enable_pin), .rx_pin(rx_pin),
      .tx_eof_done(tx_eof_done), .rx_response_start(rx_response_start), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .decoder_hold(decoder_hold), .rx_gated(rx_gated)
   );

   rfid_tag_model i_tag (
      .clock(clock), .arst_n(arst_n), .tx_eof_done(tx_eof_done), .answer_en(answer_en),
      .answer_delay(answer_delay), .rx_pin(rx_pin), .rx_response_start(rx_response_start)
   );

   // Read data stand only in the cycle after the strobe; look at them mid-cycle
   always @(posedge clock) rd_seen <= rd;
   always @(negedge clock) begin
      logic [7:0] e;
      if (rd_seen) begin
         if (expect_q.size() == 0) begin
            mismatches++;
            $display("[FAIL] %0t read data without a pending expectation", $time);
         end else begin
            e = expect_q.pop_front();
            `CHK(rdata, e)
         end
      end
   end

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      expect_q.push_back(exp);
      @(posedge clock);
      rd <= 1'b0;
   endtask

   // One slot: end of frame, then watch the blanking and silence outputs
   task automatic run_slot(input int b, input int n, input bit exp_irq);
      int fall;
      int rise;
      fall = -1;
      rise = -1;
      @(posedge clock);
      tx_eof_done <= 1'b1;
      @(posedge clock);
      tx_eof_done <= 1'b0;
      for (int k = 1; k <= n * SS + 40; k++) begin
         @(posedge clock);
         #1;
         if (fall < 0 && decoder_hold === 1'b0) fall = k;
         if (rise < 0 && irq === 1'b1) rise = k;
         if (fall < 0) `CHK(rx_gated, 1'b0)
         else `CHK(rx_gated, 1'b1)
      end
      `CHK(fall, 1 + b * BS)
      if (exp_irq) `CHK(rise, n * SS + 1)
      else `CHK(rise, -1)
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      logic [7:0] r;
      void'($urandom(75));
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      repeat (6) @(posedge clock);
      rd_reg(rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR, 8'h0e);
      rd_reg(rx_timer_pkg::RECEIVE_BLANKING_TIME_ADDR, 8'h1f);
      rd_reg(rx_timer_pkg::PROTOCOL_CONTROL_ADDR, 8'h02);
      rd_reg(rx_timer_pkg::IRQ_STATUS_ADDR, 8'h00);
      // Every rate code; 755 us and 1812 us round to 20 and 48 silence steps, 293 us to 31 blanking steps
      for (int p = 0; p < 8; p++) begin
         r = 8'($urandom_range(255, 1));
         wr_reg(rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR, r);
         wr_reg(rx_timer_pkg::RECEIVE_BLANKING_TIME_ADDR, ~r);
         rd_reg(rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR, r);
         wr_reg(rx_timer_pkg::PROTOCOL_CONTROL_ADDR, 8'(p));
         rd_reg(rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR, p[1] ? 8'h14 : 8'h30);
         rd_reg(rx_timer_pkg::RECEIVE_BLANKING_TIME_ADDR, 8'h1f);
         rd_reg(rx_timer_pkg::PROTOCOL_CONTROL_ADDR, 8'(p));
      end
      r = 8'($urandom);
      wr_reg(8'h05, r);
      rd_reg(8'h05, 8'h00);
      // Short values keep the run brief while still spanning whole steps
      wr_reg(rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR, 8'h02);
      wr_reg(rx_timer_pkg::RECEIVE_BLANKING_TIME_ADDR, 8'h02);
      rd_reg(rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR, 8'h02);
      rd_reg(rx_timer_pkg::RECEIVE_BLANKING_TIME_ADDR, 8'h02);
      run_slot(2, 2, 1'b1);
      rd_reg(rx_timer_pkg::IRQ_STATUS_ADDR, 8'h01);
      rd_reg(rx_timer_pkg::IRQ_STATUS_ADDR, 8'h00);
      @(posedge clock);
      #1;
      `CHK(irq, 1'b0)
      answer_en <= 1'b1;
      answer_delay <= 16'(1 + 2 * BS + 20);
      run_slot(2, 2, 1'b0);
      rd_reg(rx_timer_pkg::IRQ_STATUS_ADDR, 8'h00);
      // An answer inside the blanking window must not stop the silence timer
      answer_delay <= 16'h0064;
      run_slot(2, 2, 1'b1);
      rd_reg(rx_timer_pkg::IRQ_STATUS_ADDR, 8'h01);
      @(posedge clock);
      enable_pin <= 1'b0;
      repeat (8) @(posedge clock);
      enable_pin <= 1'b1;
      repeat (8) @(posedge clock);
      rd_reg(rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR, 8'h0e);
      rd_reg(rx_timer_pkg::PROTOCOL_CONTROL_ADDR, 8'h02);
      // A write while the clock enable is low must be lost
      ce <= 1'b0;
      wr_reg(rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR, 8'h5a);
      ce <= 1'b1;
      rd_reg(rx_timer_pkg::NO_RESPONSE_WAIT_TIME_ADDR, 8'h0e);
      repeat (3) @(posedge clock);
      close_out();
   end
endmodule
